// ### rtl/dmd_unit.sv
// Decimal multiply and divide datapath with result store and check.
`timescale 1ns/100ps
// How it works
// RL1: Code 44 multiplies and stores the upper accumulation register.
// RL2: Code 43 multiplies and stores the lower accumulation register.
// RL3: Code 48 divides and stores the quotient from the lower register.
// RL4: Code 49 divides and stores the remainder from the upper register.
// RL5: Multiply loads and shifts first and second operands into two registers.
// RL6: Product is sign plus 22 digits split high and low, sign algebraic.
// RL7: Multiply-high writes the upper register after any allowed shift.
// RL8: Suffix B to I suppresses checking; any other suffix checks.
// RL9: Result shift only happens in unchecked operations.
// RL10: Operands shift left, right or end-around; unchecked product shifts too.
// RL11: Checked operations check after storing, then start sub-instructions.
// RL12: Divide loads dividend into first and upper registers, divisor second.
// RL13: Divide leaves remainder in upper and quotient in lower register.
// RL14: Quotient is 11 digits plus an algebraic sign.
// RL15: Remainder carries the sign of the dividend.
// RL16: Divide-remainder writes the upper register then starts sub-instruction.
// RL17: Multiply-low and divide-quotient write the lower register.
// RL18: Suffix F starts no further sub-instruction at the end.
// RL19: Zero divisor raises an error pulse and stores nothing.
module dmd_unit (
  input wire logic clk_in, // 20 MHz clock.
  input wire logic rst_in, // Synchronous reset, high.
  input wire logic ce_in, // Clock enable; low freezes all state, though a reset still clears it.
  input wire logic start_in, // One-cycle request to run an operation.
  input wire logic [7:0] op_in, // Operation field of the request.
  input wire logic [7:0] suffix_in, // Suffix control code, ASCII.
  input wire logic [43:0] first_digits_in, // First source, 11 BCD digits.
  input wire logic first_neg_in, // First source sign, high is minus.
  input wire logic [43:0] second_digits_in, // Second source, 11 BCD digits.
  input wire logic second_neg_in, // Second source sign.
  input wire logic [1:0] first_shift_kind_in, // First operand shift kind.
  input wire logic [4:0] first_shift_cnt_in, // First operand shift count.
  input wire logic [1:0] second_shift_kind_in, // Second operand shift kind.
  input wire logic [4:0] second_shift_cnt_in, // Second operand shift count.
  input wire logic [1:0] result_shift_kind_in, // Result shift kind.
  input wire logic [4:0] result_shift_cnt_in, // Result shift count.
  output logic busy_out, // High while an operation runs.
  output logic store_valid_out, // One-cycle store to destination.
  output logic [43:0] store_digits_out, // Digits to store.
  output logic store_neg_out, // Sign to store.
  output logic check_done_out, // One-cycle pulse, check performed.
  output logic check_fail_out, // With check_done_out, check failed.
  output logic subinstr_start_out, // One-cycle pulse, start sub-instruction.
  output logic error_out // One-cycle pulse, divide refused.
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_MUL_SHIFT, ST_MUL_ADD, ST_DIV_SHIFT, ST_DIV_SUB,
    ST_RSHIFT, ST_STORE, ST_CHECK, ST_SUBINSTR
  } dmd_state_t;

  // Shift an 11 or 22 digit field; end-around wraps within that field.
  function automatic logic [87:0] dmd_shift(input logic [87:0] w,
      input logic [1:0] kind, input logic [4:0] cnt, input logic wide);
    int n;
    int j;
    logic [87:0] r;
    n = wide ? 2 * dmd_pkg::NUM_DIGITS : dmd_pkg::NUM_DIGITS;
    r = '0;
    for (int i = 0; i < 2 * dmd_pkg::NUM_DIGITS; i++) begin
      j = -1;
      if (i < n) begin
        case (kind)
          dmd_pkg::SH_LEFT: j = i - int'(cnt);
          dmd_pkg::SH_RIGHT: j = (i + int'(cnt) < n) ? i + int'(cnt) : -1;
          dmd_pkg::SH_ROT: j = (i + int'(cnt)) % n;
          default: j = i;
        endcase
      end
      if (j >= 0) begin
        r[i * dmd_pkg::DIGIT_W +: dmd_pkg::DIGIT_W] =
          w[j * dmd_pkg::DIGIT_W +: dmd_pkg::DIGIT_W];
      end
    end
    return r;
  endfunction

  // Digit-wise BCD add; carry out of the top digit is lost.
  function automatic logic [87:0] dmd_add(input logic [87:0] a,
      input logic [87:0] b);
    logic [4:0] s;
    logic c;
    logic [87:0] r;
    c = 1'b0;
    r = '0;
    for (int i = 0; i < 2 * dmd_pkg::NUM_DIGITS; i++) begin
      s = {1'b0, a[i * 4 +: 4]} + {1'b0, b[i * 4 +: 4]} + {4'h0, c};
      c = s > {1'b0, dmd_pkg::DIGIT_NINE};
      r[i * 4 +: 4] = c ? s[3:0] + dmd_pkg::DIGIT_SIX : s[3:0];
    end
    return r;
  endfunction

  // Digit-wise BCD subtract; caller guarantees a is not below b.
  function automatic logic [47:0] dmd_sub(input logic [47:0] a,
      input logic [47:0] b);
    logic [4:0] d;
    logic bw;
    logic [47:0] r;
    bw = 1'b0;
    r = '0;
    for (int i = 0; i < dmd_pkg::REM_W / dmd_pkg::DIGIT_W; i++) begin
      d = {1'b0, a[i * 4 +: 4]} - {1'b0, b[i * 4 +: 4]} - {4'h0, bw};
      bw = d[4];
      r[i * 4 +: 4] = bw ? d[3:0] + dmd_pkg::DIGIT_TEN : d[3:0];
    end
    return r;
  endfunction

  // Residue modulo nine by casting out nines.
  function automatic logic [3:0] dmd_mod9(input logic [87:0] w);
    int s;
    s = 0;
    for (int i = 0; i < 2 * dmd_pkg::NUM_DIGITS; i++) begin
      s = s + int'(w[i * 4 +: 4]);
    end
    return 4'(s % int'(dmd_pkg::MOD_NINE));
  endfunction

  dmd_state_t state;
  logic [7:0] operation_field;
  logic [7:0] suffix;
  logic [43:0] first_arith_reg;
  logic [43:0] second_arith_reg;
  logic [43:0] upper_accum_reg;
  logic [43:0] lower_accum_reg;
  logic [47:0] partial_rem;
  logic first_neg;
  logic second_neg;
  logic [3:0] idx;
  logic [3:0] rep;

  // Decode of the request and of the latched operation field.
  wire req_mul = op_in == dmd_pkg::OP_MUL_HIGH || op_in == dmd_pkg::OP_MUL_LOW;
  wire req_div = op_in == dmd_pkg::OP_DIV_QUOT || op_in == dmd_pkg::OP_DIV_REM;
  wire is_mul_hi = operation_field == dmd_pkg::OP_MUL_HIGH; // RL1
  wire is_mul_lo = operation_field == dmd_pkg::OP_MUL_LOW; // RL2
  wire is_div_quot = operation_field == dmd_pkg::OP_DIV_QUOT; // RL3
  wire is_div_rem = operation_field == dmd_pkg::OP_DIV_REM; // RL4
  wire is_mul = is_mul_hi || is_mul_lo;
  wire store_upper = is_mul_hi || is_div_rem;
  // Checking is off for suffix letters B through I.
  wire check_on = suffix < dmd_pkg::SUFFIX_LO || suffix > dmd_pkg::SUFFIX_HI; // RL8
  wire last_digit = idx == dmd_pkg::LAST_IDX;

  // Operand shifts happen as the operands are taken in.
  wire [87:0] first_wide = dmd_shift({44'h0, first_digits_in},
    first_shift_kind_in, first_shift_cnt_in, 1'b0); // RL5 RL10
  wire [87:0] second_wide = dmd_shift({44'h0, second_digits_in},
    second_shift_kind_in, second_shift_cnt_in, 1'b0); // RL5 RL10
  wire [43:0] first_shifted = first_wide[43:0];
  wire [43:0] second_shifted = second_wide[43:0];
  wire zero_divisor = second_shifted == 44'h0;
  wire start_mul = start_in && req_mul;
  wire start_div = start_in && req_div && !zero_divisor;
  wire start_err = start_in && req_div && zero_divisor;

  // Multiplier digit taken highest order first.
  wire [3:0] mul_pos = dmd_pkg::LAST_IDX - idx;
  wire [3:0] mul_digit = second_arith_reg[mul_pos * dmd_pkg::DIGIT_W +: dmd_pkg::DIGIT_W];
  wire [87:0] acc_sum = dmd_add({upper_accum_reg, lower_accum_reg},
    {44'h0, first_arith_reg});

  // Divide brings the next dividend digit down from the top of the upper register.
  wire [47:0] rem_next = {partial_rem[43:0], upper_accum_reg[43:40]};
  wire [47:0] divisor_ext = {4'h0, second_arith_reg};
  wire rem_fits = partial_rem >= divisor_ext;
  wire [47:0] rem_diff = dmd_sub(partial_rem, divisor_ext);

  // Result shift: both halves together for multiply, one register for divide.
  wire [87:0] prod_shifted = dmd_shift({upper_accum_reg, lower_accum_reg},
    result_shift_kind_in, result_shift_cnt_in, 1'b1); // RL10
  wire [87:0] rem_shifted = dmd_shift({44'h0, upper_accum_reg},
    result_shift_kind_in, result_shift_cnt_in, 1'b0);
  wire [87:0] quot_shifted = dmd_shift({44'h0, lower_accum_reg},
    result_shift_kind_in, result_shift_cnt_in, 1'b0);

  // Signs: product and quotient algebraic, remainder follows the dividend.
  wire prod_neg = first_neg ^ second_neg; // RL6 RL14
  wire result_neg = is_div_rem ? first_neg : prod_neg; // RL15
  wire [43:0] result_digits = store_upper ? upper_accum_reg : lower_accum_reg;

  // Casting-out-nines check of the finished operation.
  wire [3:0] m_a = dmd_mod9({44'h0, first_arith_reg});
  wire [3:0] m_b = dmd_mod9({44'h0, second_arith_reg});
  wire [3:0] m_c = dmd_mod9({44'h0, upper_accum_reg});
  wire [3:0] m_d = dmd_mod9({44'h0, lower_accum_reg});
  wire [3:0] m_prod = dmd_mod9({upper_accum_reg, lower_accum_reg});
  wire [7:0] m_ab = {4'h0, m_a} * {4'h0, m_b};
  wire [7:0] m_qb = {4'h0, m_d} * {4'h0, m_b} + {4'h0, m_c};
  wire mul_ok = m_ab % {4'h0, dmd_pkg::MOD_NINE} == {4'h0, m_prod};
  wire div_ok = m_qb % {4'h0, dmd_pkg::MOD_NINE} == {4'h0, m_a};
  wire check_ok = is_mul ? mul_ok : div_ok;

  assign busy_out = state != ST_IDLE;

  // Sequencer and datapath registers; while ce_in is low only a reset moves them.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      operation_field <= 8'h00;
      suffix <= 8'h00;
      first_arith_reg <= 44'h0;
      second_arith_reg <= 44'h0;
      upper_accum_reg <= 44'h0;
      lower_accum_reg <= 44'h0;
      partial_rem <= 48'h0;
      first_neg <= 1'b0;
      second_neg <= 1'b0;
      idx <= 4'h0;
      rep <= 4'h0;
      store_valid_out <= 1'b0;
      store_digits_out <= 44'h0;
      store_neg_out <= 1'b0;
      check_done_out <= 1'b0;
      check_fail_out <= 1'b0;
      subinstr_start_out <= 1'b0;
      error_out <= 1'b0;
    end else if (ce_in) begin
      store_valid_out <= 1'b0;
      check_done_out <= 1'b0;
      check_fail_out <= 1'b0;
      subinstr_start_out <= 1'b0;
      error_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          error_out <= start_err; // RL19
          if (start_mul || start_div) begin
            operation_field <= op_in;
            suffix <= suffix_in;
            first_neg <= first_neg_in;
            second_neg <= second_neg_in;
            first_arith_reg <= first_shifted; // RL5 RL12
            second_arith_reg <= second_shifted; // RL5 RL12
            upper_accum_reg <= start_div ? first_shifted : 44'h0; // RL12
            lower_accum_reg <= 44'h0;
            partial_rem <= 48'h0;
            idx <= 4'h0;
            state <= start_div ? ST_DIV_SHIFT : ST_MUL_SHIFT;
          end
        end
        ST_MUL_SHIFT: begin
          // Previous partial product moves up one digit.
          {upper_accum_reg, lower_accum_reg} <= {upper_accum_reg[39:0],
            lower_accum_reg, 4'h0}; // RL6
          rep <= mul_digit;
          state <= ST_MUL_ADD;
        end
        ST_MUL_ADD: begin
          if (rep != 4'h0) begin
            {upper_accum_reg, lower_accum_reg} <= acc_sum; // RL6
            rep <= rep - 4'h1;
          end else if (last_digit) begin
            state <= ST_RSHIFT;
          end else begin
            idx <= idx + 4'h1;
            state <= ST_MUL_SHIFT;
          end
        end
        ST_DIV_SHIFT: begin
          partial_rem <= rem_next;
          upper_accum_reg <= {upper_accum_reg[39:0], 4'h0};
          lower_accum_reg <= {lower_accum_reg[39:0], 4'h0}; // RL14
          state <= ST_DIV_SUB;
        end
        ST_DIV_SUB: begin
          if (rem_fits) begin
            partial_rem <= rem_diff;
            lower_accum_reg <= lower_accum_reg + 44'h1; // RL13
          end else if (last_digit) begin
            upper_accum_reg <= partial_rem[43:0]; // RL13
            state <= ST_RSHIFT;
          end else begin
            idx <= idx + 4'h1;
            state <= ST_DIV_SHIFT;
          end
        end
        ST_RSHIFT: begin
          // A checked result must stay as formed so the check sees it.
          if (!check_on) begin
            if (is_mul) begin
              {upper_accum_reg, lower_accum_reg} <= prod_shifted; // RL9 RL10
            end else if (is_div_rem) begin
              upper_accum_reg <= rem_shifted[43:0]; // RL9
            end else begin
              lower_accum_reg <= quot_shifted[43:0]; // RL9
            end
          end
          state <= ST_STORE;
        end
        ST_STORE: begin
          store_valid_out <= 1'b1; // RL7 RL16 RL17
          store_digits_out <= result_digits; // RL1 RL2 RL3 RL4
          store_neg_out <= result_neg;
          state <= check_on ? ST_CHECK : ST_SUBINSTR;
        end
        ST_CHECK: begin
          check_done_out <= 1'b1; // RL11
          check_fail_out <= !check_ok;
          state <= ST_SUBINSTR;
        end
        ST_SUBINSTR: begin
          subinstr_start_out <= suffix != dmd_pkg::SUFFIX_ONLY; // RL11 RL16 RL18
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Checks on the sequence; the bench drops ce_in, so the cycle-counting checks allow for ce_in low.
  a_mul_high_src: assert property (@(posedge clk_in) disable iff (rst_in) // RL1
    store_valid_out && is_mul_hi |-> store_digits_out == upper_accum_reg)
    else $error("multiply high stored the wrong register");
  a_mul_low_src: assert property (@(posedge clk_in) disable iff (rst_in) // RL2
    store_valid_out && is_mul_lo |-> store_digits_out == lower_accum_reg)
    else $error("multiply low stored the wrong register");
  a_div_quot_src: assert property (@(posedge clk_in) disable iff (rst_in) // RL3
    store_valid_out && is_div_quot |-> store_digits_out == lower_accum_reg)
    else $error("quotient store used the wrong register");
  a_div_rem_src: assert property (@(posedge clk_in) disable iff (rst_in) // RL4
    store_valid_out && is_div_rem |-> store_digits_out == upper_accum_reg)
    else $error("remainder store used the wrong register");
  a_prod_sign: assert property (@(posedge clk_in) disable iff (rst_in) // RL6
    store_valid_out && !is_div_rem |-> store_neg_out == (first_neg ^ second_neg))
    else $error("product or quotient sign is not algebraic");
  a_rem_sign: assert property (@(posedge clk_in) disable iff (rst_in) // RL15
    store_valid_out && is_div_rem |-> store_neg_out == first_neg)
    else $error("remainder sign differs from dividend");
  a_check_gate: assert property (@(posedge clk_in) disable iff (rst_in) // RL8
    check_done_out |-> check_on)
    else $error("check ran although suppressed");
  a_check_order: assert property (@(posedge clk_in) disable iff (rst_in) // RL11
    store_valid_out && check_on && ce_in |=> check_done_out ##1 subinstr_start_out || !ce_in)
    else $error("check did not follow store");
  a_checked_noshift: assert property (@(posedge clk_in) disable iff (rst_in) // RL9
    state == ST_RSHIFT && check_on && ce_in |=> $stable(upper_accum_reg)
      && $stable(lower_accum_reg))
    else $error("checked result was shifted");
  a_suffix_only: assert property (@(posedge clk_in) disable iff (rst_in) // RL18
    subinstr_start_out |-> suffix != dmd_pkg::SUFFIX_ONLY)
    else $error("suffix F started a sub-instruction");
  a_zero_div_err: assert property (@(posedge clk_in) disable iff (rst_in) // RL19
    state == ST_IDLE && start_err && ce_in |=> error_out && !busy_out)
    else $error("zero divisor not refused");
  a_div_load: assert property (@(posedge clk_in) disable iff (rst_in) // RL12
    state == ST_IDLE && start_div && ce_in |=> upper_accum_reg == first_arith_reg)
    else $error("dividend not loaded into both registers");

  c_mul_high: cover property (@(posedge clk_in) store_valid_out && is_mul_hi);
  c_div_rem: cover property (@(posedge clk_in) store_valid_out && is_div_rem);
  c_check_done: cover property (@(posedge clk_in) check_done_out && !check_fail_out);
  c_div_error: cover property (@(posedge clk_in) error_out);

endmodule

// ### rtl/dmd_pkg.sv
// Package of constants for the decimal multiply and divide unit.
package dmd_pkg;
  localparam int NUM_DIGITS = 11;
  localparam int DIGIT_W = 4;
  localparam int WORD_W = 44;
  localparam int ACC_W = 88;
  localparam int REM_W = 48;
  localparam int IDX_W = 4;
  localparam logic [3:0] LAST_IDX = 4'ha;
  localparam logic [3:0] DIGIT_NINE = 4'h9;
  localparam logic [3:0] DIGIT_TEN = 4'ha;
  localparam logic [3:0] DIGIT_SIX = 4'h6;
  localparam logic [4:0] SHIFT_NONE = 5'h00;
  // Operation codes, the trailing S of the printed code dropped.
  localparam logic [7:0] OP_MUL_HIGH = 8'h44;
  localparam logic [7:0] OP_MUL_LOW = 8'h43;
  localparam logic [7:0] OP_DIV_QUOT = 8'h48;
  localparam logic [7:0] OP_DIV_REM = 8'h49;
  // Suffix codes are ASCII letters; B through I suppress checking.
  localparam logic [7:0] SUFFIX_LO = 8'h42;
  localparam logic [7:0] SUFFIX_HI = 8'h49;
  localparam logic [7:0] SUFFIX_ONLY = 8'h46;
  // Shift kinds.
  localparam logic [1:0] SH_NONE = 2'h0;
  localparam logic [1:0] SH_LEFT = 2'h1;
  localparam logic [1:0] SH_RIGHT = 2'h2;
  localparam logic [1:0] SH_ROT = 2'h3;
  localparam logic [3:0] MOD_NINE = 4'h9;
endpackage

// ### tb/dmd_word_store.sv
// Behavioural destination storage that takes the unit's result stores.
`timescale 1ns/100ps
module dmd_word_store (
  input wire logic clk_in, // Shared clock.
  input wire logic ce_in, // Clock enable; a frozen strobe is not a new store.
  input wire logic clear_in, // Clears the store count, high.
  input wire logic store_valid_in, // Store strobe from the unit.
  input wire logic [43:0] digits_in, // Digits to keep.
  input wire logic neg_in, // Sign to keep.
  output logic [43:0] word_out, // Last stored digits.
  output logic neg_out, // Last stored sign.
  output int count_out // Number of stores taken.
);
  // The stored word is memory and survives a reset; only the count of stores clears.
  always_ff @(posedge clk_in) begin
    if (clear_in) begin
      count_out <= 0;
    end else if (store_valid_in && ce_in) begin
      word_out <= digits_in;
      neg_out <= neg_in;
      count_out <= count_out + 1;
    end
  end
endmodule

// ### tb/dmd_unit_tb.sv
// Self-checking testbench for the decimal multiply and divide unit.
`timescale 1ns/100ps
module dmd_unit_tb;
  typedef struct {
    logic [7:0] op; logic [7:0] suf; logic [43:0] a; logic an; logic [43:0] b; logic bn;
    logic [6:0] fs; logic [6:0] ss; logic [6:0] rs; logic [43:0] res; logic rn;
  } dmd_row_t;
  logic clk_in, rst_in, ce_in, start_in, first_neg_in, second_neg_in;
  logic [7:0] op_in, suffix_in;
  logic [43:0] first_digits_in, second_digits_in, store_digits_out, word;
  logic [1:0] first_shift_kind_in, second_shift_kind_in, result_shift_kind_in;
  logic [4:0] first_shift_cnt_in, second_shift_cnt_in, result_shift_cnt_in;
  logic busy_out, store_valid_out, store_neg_out, check_done_out, check_fail_out;
  logic subinstr_start_out, error_out, word_neg;
  int err_count, tests_run, stores, base;
  dmd_row_t rows[14];
  dmd_row_t r;
  dmd_unit dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .start_in(start_in),
    .op_in(op_in), .suffix_in(suffix_in), .first_digits_in(first_digits_in),
    .first_neg_in(first_neg_in), .second_digits_in(second_digits_in),
    .second_neg_in(second_neg_in), .first_shift_kind_in(first_shift_kind_in),
    .first_shift_cnt_in(first_shift_cnt_in), .second_shift_kind_in(second_shift_kind_in),
    .second_shift_cnt_in(second_shift_cnt_in), .result_shift_kind_in(result_shift_kind_in),
    .result_shift_cnt_in(result_shift_cnt_in), .busy_out(busy_out),
    .store_valid_out(store_valid_out), .store_digits_out(store_digits_out),
    .store_neg_out(store_neg_out), .check_done_out(check_done_out),
    .check_fail_out(check_fail_out), .subinstr_start_out(subinstr_start_out),
    .error_out(error_out));
  dmd_word_store mem (.clk_in(clk_in), .ce_in(ce_in), .clear_in(rst_in),
    .store_valid_in(store_valid_out),
    .digits_in(store_digits_out), .neg_in(store_neg_out), .word_out(word),
    .neg_out(word_neg), .count_out(stores));
  // A 50 ns clock; inputs always move 1 ns after the rising edge.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic cmp_bit(input logic got, input logic want);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("CHECK FAILED at %0t: flag %b, wanted %b", $time, got, want);
    end
  endtask
  task automatic cmp_word(input logic [43:0] got, input logic [43:0] want);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("CHECK FAILED at %0t: digits %h, wanted %h", $time, got, want);
    end
  endtask
  task automatic end_of_test;
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  // Presents one request for one cycle; operands and shifts stay put afterwards.
  task automatic drive(input dmd_row_t x);
    tick();
    op_in = x.op;
    suffix_in = x.suf;
    first_digits_in = x.a;
    first_neg_in = x.an;
    second_digits_in = x.b;
    second_neg_in = x.bn;
    {first_shift_kind_in, first_shift_cnt_in} = x.fs;
    {second_shift_kind_in, second_shift_cnt_in} = x.ss;
    {result_shift_kind_in, result_shift_cnt_in} = x.rs;
    start_in = 1'b1;
    tick();
    start_in = 1'b0;
  endtask
  // Waits for the store, then follows the check and sub-instruction pulses.
  task automatic finish(input dmd_row_t x);
    logic chk, sub;
    int n;
    chk = (x.suf < 8'h42) || (x.suf > 8'h49);
    sub = (x.suf !== 8'h46);
    n = 0;
    while (store_valid_out !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    cmp_bit(store_valid_out, 1'b1);
    cmp_word(store_digits_out, x.res);
    cmp_bit(store_neg_out, x.rn);
    tick();
    cmp_bit(check_done_out, chk);
    if (chk) begin
      cmp_bit(check_fail_out, 1'b0);
      tick();
    end
    cmp_bit(subinstr_start_out, sub);
    cmp_word(word, x.res);
    n = 0;
    while (busy_out !== 1'b0 && n < 4) begin
      tick();
      n++;
    end
    cmp_bit(busy_out, 1'b0);
  endtask
  initial begin
    // Watchdog: the whole run needs well under 20000 cycles.
    #1000000;
    err_count++;
    end_of_test();
  end
  initial begin
    err_count = 0;
    tests_run = 0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    start_in = 1'b0;
    r = '{8'h00, 8'h30, 44'h0, 0, 44'h0, 0, 0, 0, 0, 44'h0, 0};
    {op_in, suffix_in, first_digits_in, first_neg_in} = {8'h00, 8'h30, 44'h0, 1'b0};
    {second_digits_in, second_neg_in} = {44'h0, 1'b0};
    {first_shift_kind_in, first_shift_cnt_in, second_shift_kind_in} = 9'h000;
    {second_shift_cnt_in, result_shift_kind_in, result_shift_cnt_in} = 12'h000;
    rows = '{
      '{8'h44, 8'h30, 44'h00947892347, 0, 44'h00572823041, 0, 0, 0, 0, 44'h00005429745, 0},
      '{8'h43, 8'h43, 44'h00947892347, 1, 44'h00572823041, 0, 0, 0, 0, 44'h76749167227, 1},
      '{8'h48, 8'h30, 44'h00456793254, 0, 44'h8490, 0, 0, 0, 0, 44'h53803, 0},
      '{8'h49, 8'h44, 44'h00456793254, 0, 44'h8490, 1, 0, 0, 0, 44'h5784, 0},
      '{8'h48, 8'h41, 44'h00456793254, 1, 44'h8490, 0, 0, 0, 0, 44'h53803, 1},
      '{8'h49, 8'h41, 44'h00456793254, 1, 44'h8490, 1, 0, 0, 0, 44'h5784, 1},
      '{8'h43, 8'h30, 44'h12, 0, 44'h3, 0, 7'h21, 0, 0, 44'h360, 0},
      '{8'h43, 8'h30, 44'h1, 0, 44'h2, 0, 7'h61, 0, 0, 44'h20000000000, 0},
      '{8'h43, 8'h30, 44'h3, 0, 44'h120, 0, 0, 7'h41, 0, 44'h36, 0},
      '{8'h43, 8'h42, 44'h6, 0, 44'h7, 0, 0, 0, 7'h21, 44'h420, 0},
      '{8'h43, 8'h30, 44'h6, 0, 44'h7, 0, 0, 0, 7'h21, 44'h42, 0},
      '{8'h48, 8'h45, 44'h100, 0, 44'h5, 0, 0, 0, 7'h41, 44'h2, 0},
      '{8'h44, 8'h47, 44'h6, 0, 44'h7, 0, 0, 0, 7'h61, 44'h20000000000, 0},
      '{8'h49, 8'h30, 44'h17, 0, 44'h7, 0, 7'h21, 0, 0, 44'h2, 0}};
    repeat (4) tick();
    rst_in = 1'b0;
    // Outputs are quiet straight after reset.
    cmp_bit(busy_out | store_valid_out | check_done_out | subinstr_start_out, 1'b0);
    cmp_bit(error_out, 1'b0);
    cmp_word(store_digits_out, 44'h0);
    foreach (rows[i]) begin
      drive(rows[i]);
      finish(rows[i]);
    end
    // Every suffix from A to J on the same small product.
    for (int s = 8'h41; s <= 8'h4a; s++) begin
      r = '{dmd_pkg::OP_MUL_LOW, s[7:0], 44'h6, 0, 44'h7, 0, 0, 0, 0, 44'h42, 0};
      drive(r);
      finish(r);
    end
    // A zero divisor is refused at once and nothing reaches storage.
    base = stores;
    r = '{dmd_pkg::OP_DIV_QUOT, 8'h30, 44'h55, 0, 44'h0, 0, 0, 0, 0, 44'h0, 0};
    drive(r);
    cmp_bit(error_out, 1'b1);
    repeat (5) tick();
    cmp_bit(busy_out, 1'b0);
    cmp_bit(stores == base, 1'b1);
    // A request while busy is ignored, and a frozen enable only stretches the run.
    r = '{dmd_pkg::OP_MUL_LOW, 8'h30, 44'h6, 0, 44'h7, 0, 0, 0, 0, 44'h42, 0};
    drive(r);
    // Let one edge pass so start_in is not lowered and raised in one step.
    tick();
    op_in = dmd_pkg::OP_MUL_HIGH;
    start_in = 1'b1;
    ce_in = 1'b0;
    repeat (10) tick();
    cmp_bit(busy_out, 1'b1);
    ce_in = 1'b1;
    tick();
    start_in = 1'b0;
    op_in = dmd_pkg::OP_MUL_LOW;
    finish(r);
    // Reset in mid-run abandons the operation without a store.
    base = stores;
    drive(r);
    repeat (3) tick();
    rst_in = 1'b1;
    tick();
    rst_in = 1'b0;
    cmp_bit(busy_out, 1'b0);
    repeat (300) tick();
    cmp_bit(stores == 0, 1'b1);
    drive(rows[0]);
    finish(rows[0]);
    end_of_test();
  end
endmodule
